// ### rtl/anc_notch_compand.sv
// Per-channel notch filter with atomic coefficient update and G.711 compander
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "anc_params.svh"

module anc_notch_compand #(
	parameter int CH = 4,
	parameter int W = 24,
	parameter int CW = 16
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_smp_valid,
	input wire logic [$clog2(CH)-1:0] i_smp_chan,
	input wire logic [W-1:0] i_smp_data,
	output logic o_out_valid,
	output logic [$clog2(CH)-1:0] o_out_chan,
	output logic [W-1:0] o_out_lin,
	output logic [7:0] o_out_code,
	output anc_pkg::anc_cmp_mode_type o_out_mode
);
	import anc_pkg::*;

	localparam int CHB = $clog2(CH);

	typedef struct packed {
		logic [CH-1:0] en;
		anc_cmp_mode_type mode;
		logic [CH-1:0][CW-1:0] pend_bw;
		logic [CH-1:0][CW-1:0] pend_cc;
		logic [CH-1:0][CW-1:0] act_bw;
		logic [CH-1:0][CW-1:0] act_cc;
		logic [CH-1:0] dirty;
		logic apply;
		logic [CH-1:0][W-1:0] x1;
		logic [CH-1:0][W-1:0] x2;
		logic [CH-1:0][W-1:0] y1;
		logic [CH-1:0][W-1:0] y2;
		logic ov;
		logic [CHB-1:0] och;
		logic [W-1:0] olin;
		logic [7:0] ocode;
		anc_cmp_mode_type omode;
	} anc_state_type;

	anc_state_type state_reg;
	anc_state_type state_next;

	// ------------------------------------------------------------------------
	// Arithmetic helpers
	// ------------------------------------------------------------------------
	function automatic logic [3:0] msb_pos(input logic [13:0] v);
		logic [3:0] p;
		p = 4'h0;
		for (int i = 0; i < 14; i++) begin
			if (v[i]) begin
				p = 4'(i);
			end
		end
		return p;
	endfunction

	// Second order allpass, scaled by 2^13; coefficients are the negated A terms
	function automatic logic signed [W-1:0] allpass(input logic signed [W-1:0] x,
			input logic signed [W-1:0] x1, input logic signed [W-1:0] x2,
			input logic signed [W-1:0] y1, input logic signed [W-1:0] y2,
			input logic signed [CW-1:0] cb, input logic signed [CW-1:0] cc);
		logic signed [W+CW+3:0] acc;
		acc = (W+CW+4)'(x2) <<< `ANC_CB_SHIFT;
		acc = acc - cb * x + cb * y2;
		acc = acc + ((cc * y1 - cc * x1) <<< (`ANC_CB_SHIFT - `ANC_CC_SHIFT));
		return acc[W+`ANC_CB_SHIFT-1:`ANC_CB_SHIFT];
	endfunction

	function automatic logic [7:0] mu_enc(input logic [W-1:0] s);
		logic [`ANC_MU_BITS-1:0] t;
		logic [12:0] mag;
		logic [13:0] m;
		logic [13:0] sh;
		logic [3:0] p;
		logic [2:0] ex;
		t = s[W-1 -: `ANC_MU_BITS];
		// One's complement keeps the code symmetric around zero
		mag = t[13] ? ~t[12:0] : t[12:0];
		if (mag > `ANC_MU_CLIP) begin
			mag = `ANC_MU_CLIP;
		end
		m = {1'b0, mag} + `ANC_MU_BIAS;
		p = msb_pos(m);
		ex = (p < `ANC_MU_SEG_LSB) ? 3'h0 : 3'(p - `ANC_MU_SEG_LSB);
		sh = m >> (4'(ex) + 4'h1);
		return {~t[13], ~ex, ~sh[3:0]};
	endfunction

	function automatic logic [7:0] a_enc(input logic [W-1:0] s);
		logic [`ANC_A_BITS-1:0] t;
		logic [11:0] mag;
		logic [11:0] sh;
		logic [3:0] p;
		logic [2:0] ex;
		t = s[W-1 -: `ANC_A_BITS];
		mag = t[12] ? ~t[11:0] : t[11:0];
		p = msb_pos({2'h0, mag});
		// Below the first segment the curve is linear
		if (p <= `ANC_A_SEG_LSB) begin
			ex = 3'h0;
			sh = mag >> 1;
		end else begin
			ex = 3'(p - `ANC_A_SEG_LSB);
			sh = mag >> ex;
		end
		return {~t[12], ex, sh[3:0]} ^ `ANC_A_XOR;
	endfunction

	// ------------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------------
	logic acc_phase;
	logic wr;
	logic coef_hit;
	logic [11:0] coef_off;
	logic [CHB-1:0] coef_ch;
	logic coef_sel;
	logic mapped;

	assign acc_phase = i_psel && i_penable;
	assign wr = acc_phase && i_pwrite;
	assign coef_off = i_paddr - `ANC_REG_COEF_BASE;
	assign coef_hit = (i_paddr >= `ANC_REG_COEF_BASE) && (i_paddr[1:0] == 2'h0)
		&& (coef_off < 12'(CH) * `ANC_COEF_STRIDE);
	assign coef_ch = CHB'(coef_off / `ANC_COEF_STRIDE);
	assign coef_sel = (coef_off % `ANC_COEF_STRIDE) == `ANC_COEF_CENTRE_OFS;
	assign mapped = coef_hit || i_paddr == `ANC_REG_CTRL || i_paddr == `ANC_REG_STAT;
	assign o_pready = 1'b1;
	assign o_pslverr = acc_phase && !mapped;

	always_comb begin
		o_prdata = 32'h0000_0000;
		if (acc_phase && !i_pwrite) begin
			if (i_paddr == `ANC_REG_CTRL) begin
				o_prdata[`ANC_CTRL_EN_LSB +: CH] = state_reg.en;
				o_prdata[`ANC_CTRL_MODE_LSB +: 2] = state_reg.mode;
			end else if (i_paddr == `ANC_REG_STAT) begin
				o_prdata[CH-1:0] = state_reg.dirty;
				o_prdata[`ANC_STAT_APPLY_BIT] = state_reg.apply;
			end else if (coef_hit) begin
				// Pending value reads back; the update bit stays zero
				o_prdata[CW-1:0] = coef_sel ? state_reg.pend_cc[coef_ch]
					: state_reg.pend_bw[coef_ch];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	logic signed [W-1:0] ap;
	logic [W:0] nsum;
	logic [W-1:0] filt;

	always_comb begin
		ap = allpass(i_smp_data, state_reg.x1[i_smp_chan], state_reg.x2[i_smp_chan],
			state_reg.y1[i_smp_chan], state_reg.y2[i_smp_chan],
			state_reg.act_bw[i_smp_chan], state_reg.act_cc[i_smp_chan]);
		nsum = {i_smp_data[W-1], i_smp_data} + {ap[W-1], ap};
		filt = nsum[W:1];
		state_next = state_reg;
		state_next.ov = 1'b0;
		// Swap only between samples so no output mixes old and new sets
		if (state_reg.apply && !i_smp_valid) begin
			state_next.act_bw = state_reg.pend_bw;
			state_next.act_cc = state_reg.pend_cc;
			state_next.dirty = '0;
			state_next.apply = 1'b0;
		end
		// A write in the apply cycle leaves its value pending afterwards
		if (wr && i_paddr == `ANC_REG_CTRL) begin
			state_next.en = i_pwdata[`ANC_CTRL_EN_LSB +: CH];
			unique case (i_pwdata[`ANC_CTRL_MODE_LSB +: 2])
				2'h1: state_next.mode = ANC_CMP_MU;
				2'h2: state_next.mode = ANC_CMP_ALAW;
				default: state_next.mode = ANC_CMP_OFF;
			endcase
		end else if (wr && coef_hit) begin
			if (coef_sel) begin
				state_next.pend_cc[coef_ch] = i_pwdata[CW-1:0];
			end else begin
				state_next.pend_bw[coef_ch] = i_pwdata[CW-1:0];
			end
			state_next.dirty[coef_ch] = 1'b1;
			if (i_pwdata[`ANC_UPD_BIT]) begin
				state_next.apply = 1'b1;
			end
		end
		if (i_smp_valid) begin
			// History runs even when bypassed so enabling starts clean
			state_next.x1[i_smp_chan] = i_smp_data;
			state_next.x2[i_smp_chan] = state_reg.x1[i_smp_chan];
			state_next.y1[i_smp_chan] = ap;
			state_next.y2[i_smp_chan] = state_reg.y1[i_smp_chan];
			state_next.ov = 1'b1;
			state_next.och = i_smp_chan;
			state_next.omode = state_reg.mode;
			state_next.olin = state_reg.en[i_smp_chan] ? filt : i_smp_data;
			unique case (state_reg.mode)
				ANC_CMP_MU: state_next.ocode = mu_enc(state_next.olin);
				ANC_CMP_ALAW: state_next.ocode = a_enc(state_next.olin);
				default: state_next.ocode = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			state_reg <= '0;
			state_reg.mode <= ANC_CMP_OFF;
			state_reg.omode <= ANC_CMP_OFF;
			for (int c = 0; c < CH; c++) begin
				state_reg.pend_bw[c] <= `ANC_COEF_RST;
				state_reg.pend_cc[c] <= `ANC_COEF_RST;
				state_reg.act_bw[c] <= `ANC_COEF_RST;
				state_reg.act_cc[c] <= `ANC_COEF_RST;
			end
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_out_valid = state_reg.ov;
	assign o_out_chan = state_reg.och;
	assign o_out_lin = state_reg.olin;
	assign o_out_code = state_reg.ocode;
	assign o_out_mode = state_reg.omode;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb_chk @(posedge i_ref_clk);
	endclocking
	default disable iff (i_reset);

	a_rd_upd_zero: assert property (acc_phase && !i_pwrite && coef_hit
		|-> o_prdata[`ANC_UPD_BIT] == 1'b0)
		else $error("update bit read back as one");

	a_pend_hold: assert property (wr && coef_hit && !i_pwdata[`ANC_UPD_BIT] && !state_reg.apply
		|=> $stable(state_reg.act_bw) && $stable(state_reg.act_cc))
		else $error("active coefficients moved without update");

	a_pend_mark: assert property (wr && coef_hit |=> state_reg.dirty[$past(coef_ch)])
		else $error("coefficient write not marked pending");

	// A write landing on the swap edge keeps its own channel pending
	a_upd_activate: assert property (wr && coef_hit && i_pwdata[`ANC_UPD_BIT]
		##1 !i_smp_valid |=> state_reg.act_bw == $past(state_reg.pend_bw)
		&& state_reg.act_cc == $past(state_reg.pend_cc)
		&& (state_reg.dirty == '0 || $past(wr && coef_hit)))
		else $error("pending set not activated together");

	a_apply_gap: assert property (!$stable(state_reg.act_bw) || !$stable(state_reg.act_cc)
		|-> $past(!i_smp_valid) && $past(state_reg.apply))
		else $error("coefficients swapped during a sample");

	a_bypass_pass: assert property (i_smp_valid && !state_reg.en[i_smp_chan]
		|=> o_out_valid && o_out_lin == $past(i_smp_data))
		else $error("bypassed channel altered sample");

	a_out_pulse: assert property (o_out_valid == $past(i_smp_valid))
		else $error("output strobe not one cycle after sample");

	a_mu_zero: assert property (o_out_valid && o_out_mode == ANC_CMP_MU
		&& o_out_lin[W-1 -: `ANC_MU_BITS] == '0 |-> o_out_code == `ANC_MU_ZERO)
		else $error("mu-law zero code wrong");

	a_alaw_zero: assert property (o_out_valid && o_out_mode == ANC_CMP_ALAW
		&& o_out_lin[W-1 -: `ANC_A_BITS] == '0 |-> o_out_code == `ANC_A_ZERO)
		else $error("A-law zero code wrong");

	// A clipped positive magnitude always gives the top code, as do magnitudes from 13'h1edf up
	a_mu_top: assert property (o_out_valid && o_out_mode == ANC_CMP_MU
		&& o_out_lin[W-1] == 1'b0 && o_out_lin[W-2 -: `ANC_MU_BITS-1] >= `ANC_MU_CLIP
		|-> o_out_code == `ANC_MU_MAX)
		else $error("mu-law top segment code wrong");

	a_off_code: assert property (o_out_valid && o_out_mode == ANC_CMP_OFF
		|-> o_out_code == 8'h00)
		else $error("code not zero with compander off");

endmodule

// ### rtl/anc_params.svh
// Register map, field positions and fixed numbers of the notch and compander path
`ifndef ANC_PARAMS_SVH
`define ANC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define ANC_REG_CTRL 12'h000
`define ANC_REG_STAT 12'h004
`define ANC_REG_COEF_BASE 12'h010
`define ANC_COEF_STRIDE 12'h008
`define ANC_COEF_CENTRE_OFS 12'h004

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ANC_CTRL_EN_LSB 0
`define ANC_CTRL_MODE_LSB 8
`define ANC_STAT_APPLY_BIT 8
`define ANC_UPD_BIT 31

// ----------------------------------------------------------------------------
// Reset values and arithmetic constants
// ----------------------------------------------------------------------------
`define ANC_COEF_RST 16'h0000
`define ANC_CB_SHIFT 13
`define ANC_CC_SHIFT 12
`define ANC_MU_BITS 14
`define ANC_A_BITS 13
`define ANC_MU_BIAS 14'h0021
`define ANC_MU_CLIP 13'h1fde
`define ANC_MU_SEG_LSB 4'h5
`define ANC_A_SEG_LSB 4'h4
`define ANC_A_XOR 8'h55
`define ANC_MU_ZERO 8'hff
`define ANC_MU_MAX 8'h80
`define ANC_A_ZERO 8'hd5

`endif

// ### rtl/anc_pkg.sv
// Shared types of the notch and compander path
package anc_pkg;
	typedef enum logic [1:0] {ANC_CMP_OFF, ANC_CMP_MU, ANC_CMP_ALAW} anc_cmp_mode_type;
endpackage

// ### testbench/anc_adc_model.sv
// Behavioural model of the ADC sample source feeding the notch path
`timescale 1ns/1ps
module anc_adc_model (
	input wire logic i_ref_clk,
	output logic o_smp_valid,
	output logic [1:0] o_smp_chan,
	output logic [23:0] o_smp_data
);
	initial begin
		o_smp_valid = 1'b0;
		o_smp_chan = 2'h0;
		o_smp_data = 24'h000000;
	end
	// Off-frame lines show the inverse, so a stale word never passes for a sample
	task automatic send(input logic [1:0] c, input logic [23:0] d, input int n);
		@(posedge i_ref_clk);
		o_smp_valid <= 1'b1;
		o_smp_chan <= c;
		o_smp_data <= d;
		repeat (n) @(posedge i_ref_clk);
		o_smp_valid <= 1'b0;
		o_smp_chan <= ~c;
		o_smp_data <= ~d;
	endtask
endmodule

// ### testbench/test_anc_notch_compand.sv
// Self-checking bench of the notch and compander path
`timescale 1ns/1ps
`include "anc_params.svh"
module test_anc_notch_compand;
	import anc_pkg::*;
	typedef struct {
		logic [1:0] mode;
		logic [23:0] x;
		logic [7:0] code;
		logic [1:0] om;
	} anc_row_type;
	localparam logic [11:0] cc2 = `ANC_REG_COEF_BASE + 12'h010 + `ANC_COEF_CENTRE_OFS;
	localparam logic [11:0] cb3 = `ANC_REG_COEF_BASE + 12'h018;
	localparam logic [11:0] cc3 = cb3 + `ANC_COEF_CENTRE_OFS;
	logic clk, rst, psel, pen, pwr, pready, pslverr, sv, ovalid, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] sc, oc;
	logic [23:0] sd, olin;
	logic [7:0] ocode;
	anc_cmp_mode_type omode;
	int n_fail = 0;
	int check_count = 0;
	anc_row_type rows [10] = '{
		'{2'h1, 24'h000000, 8'hff, 2'h1},
		'{2'h1, 24'h000400, 8'hfe, 2'h1},
		'{2'h1, 24'h019000, 8'hdf, 2'h1},
		'{2'h1, 24'h7f7800, 8'h80, 2'h1},
		'{2'h1, 24'h7ffc00, 8'h80, 2'h1},
		'{2'h1, 24'hfffc00, 8'h7f, 2'h1},
		'{2'h2, 24'h000000, 8'hd5, 2'h2},
		'{2'h2, 24'h010000, 8'hc5, 2'h2},
		'{2'h2, 24'h7ff800, 8'haa, 2'h2},
		'{2'h3, 24'h123456, 8'h00, 2'h0}};

	anc_notch_compand DUT (
		.i_ref_clk(clk),
		.i_reset(rst),
		.i_psel(psel),
		.i_penable(pen),
		.i_pwrite(pwr),
		.i_paddr(paddr),
		.i_pwdata(pwdata),
		.o_prdata(prdata),
		.o_pready(pready),
		.o_pslverr(pslverr),
		.i_smp_valid(sv),
		.i_smp_chan(sc),
		.i_smp_data(sd),
		.o_out_valid(ovalid),
		.o_out_chan(oc),
		.o_out_lin(olin),
		.o_out_code(ocode),
		.o_out_mode(omode)
	);
	anc_adc_model PART (
		.i_ref_clk(clk),
		.o_smp_valid(sv),
		.o_smp_chan(sc),
		.o_smp_data(sd)
	);

	// ------
	// Tasks
	// ------
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		check_count++;
		if (g !== x) begin
			n_fail++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask
	// Answer and read data are taken at the edge that ends the access phase
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h00000000);
		chk(n, x, rd);
	endtask
	// Output is registered on the taking edge and checked 1 ns after it
	task automatic smp(input logic [1:0] c, input logic [23:0] d, input logic [23:0] y);
		PART.send(c, d, 1);
		#1;
		chk("valid", 32'h1, ovalid);
		chk("chan", c, oc);
		chk("lin", y, olin);
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ------
	// Stimulus
	// ------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#300000;
		n_fail++;
		stop_test;
	end
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("valid_rst", 32'h0, ovalid);
		chk("pready_rst", 32'h1, pready);
		rdc("ctrl_rst", `ANC_REG_CTRL, 32'h00000000);
		rdc("stat_rst", `ANC_REG_STAT, 32'h00000000);
		foreach (rows[i]) begin
			apb(1'b1, `ANC_REG_CTRL, {22'h000000, rows[i].mode, 8'h00});
			rdc("ctrl", `ANC_REG_CTRL, {22'h000000, rows[i].om, 8'h00});
			smp(2'(i), rows[i].x, rows[i].x);
			chk("code", rows[i].code, ocode);
			chk("mode", rows[i].om, omode);
		end
		apb(1'b0, 12'hffc, 32'h00000000);
		chk("slverr", 32'h1, err);
		chk("unmapped", 32'h0, rd);
		// Two zero samples flush the input history the table rows left behind
		repeat (2) begin
			smp(2'h2, 24'h000000, 24'h000000);
			smp(2'h3, 24'h000000, 24'h000000);
		end
		apb(1'b1, `ANC_REG_CTRL, 32'h0000000c);
		smp(2'h2, 24'd1000, 24'h0001f4);
		smp(2'h3, 24'd1000, 24'h0001f4);
		apb(1'b1, cc2, 32'h00001000);
		rdc("stat_pend", `ANC_REG_STAT, 32'h00000004);
		rdc("coef_pend", cc2, 32'h00001000);
		smp(2'h2, 24'h000000, 24'h000000);
		apb(1'b1, cc3, 32'h00001000);
		apb(1'b1, cb3, 32'h80000000);
		rdc("stat_apply", `ANC_REG_STAT, 32'h00000000);
		rdc("upd_bit", cb3, 32'h00000000);
		smp(2'h3, 24'h000000, 24'hfffe0c);
		fork
			PART.send(2'h0, 24'h000400, 12);
			begin
				apb(1'b1, cc2, 32'h80000000);
				rdc("apply_wait", `ANC_REG_STAT, 32'h00000104);
			end
		join
		repeat (2) @(posedge clk);
		rdc("apply_done", `ANC_REG_STAT, 32'h00000000);
		stop_test;
	end
endmodule
